// ==== shared/nco_defs.svh ====
// constants shared by both ends of the nco serial control link
`ifndef NCO_DEFS_SVH
`define NCO_DEFS_SVH
`define NCO_WORD_BITS     16
`define NCO_CMD_HI        15
`define NCO_CMD_LO        14
`define NCO_CMD_CTRL      2'h0
`define NCO_CMD_TUNE_A    2'h1
`define NCO_CMD_TUNE_B    2'h2
`define NCO_CMD_PHASE     2'h3
`define NCO_PH_SEL_BIT    13
`define NCO_PH_MSB        11
`define NCO_TW_MSB        13
`define NCO_CT_B28        13
`define NCO_CT_HLB        12
`define NCO_CT_FSEL       11
`define NCO_CT_PSEL       10
`define NCO_CT_RESET      8
`define NCO_CT_HALT       7
`define NCO_CT_PDN        6
`define NCO_CT_MSBOUT     5
`define NCO_CT_FULLRATE   3
`define NCO_CT_RAMP       1
`define NCO_RUN_LATENCY   3'h7
`define NCO_CTRL_RESET    16'h0100
`define NCO_ACC_BITS      28
`define NCO_DAC_BITS      10
`endif

// ==== shared/nco_pkg.sv ====
// types shared by both ends of the nco serial control link
package nco_pkg;
    typedef enum logic [1:0] {
        NCO_OUT_SINE,
        NCO_OUT_RAMP,
        NCO_OUT_MSB_HALF,
        NCO_OUT_MSB
    } nco_out_t;
    typedef enum logic [1:0] {
        NCO_HS_IDLE,
        NCO_HS_SETUP,
        NCO_HS_SHIFT,
        NCO_HS_DONE
    } nco_hs_t;
endpackage : nco_pkg

// ==== shared/nco_link_if.sv ====
// three-wire serial link between host and nco device
`timescale 1ns/10ps
interface nco_link_if;
    logic serial_clock;
    logic frame_strobe_n;
    logic serial_input_line;
    modport host (
        output serial_clock,
        output frame_strobe_n,
        output serial_input_line
    );
    modport device (
        input serial_clock,
        input frame_strobe_n,
        input serial_input_line
    );
endinterface : nco_link_if

// ==== design/nco_host.sv ====
// host end: shifts 16-bit command words out over the serial link
`timescale 1ns/10ps
`include "nco_defs.svh"
module nco_host #(
    parameter int HALF_DIV = 4
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // link
    nco_link_if.host         link,
    // user side
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [15:0] cmd_word,
    output logic             cmd_done
);
    typedef struct packed {
        nco_pkg::nco_hs_t state;
        logic [7:0]       div;
        logic [4:0]       bits;
        logic [15:0]      shreg;
        logic             sck;
        logic             fs_n;
        logic             done;
    } nco_hst_t;
    nco_hst_t q, d;

    // ==================================
    // transmit sequencer
    always_comb begin
        d      = q;
        d.done = 1'b0;
        case (q.state)
            nco_pkg::NCO_HS_IDLE: begin
                d.sck = 1'b1;
                if (cmd_valid) begin
                    d.fs_n  = 1'b0;
                    d.shreg = cmd_word;
                    d.bits  = 5'h0;
                    d.div   = 8'h0;
                    d.state = nco_pkg::NCO_HS_SETUP;
                end
            end
            nco_pkg::NCO_HS_SETUP: begin
                d.div = q.div + 8'h1;
                if (q.div == 8'(HALF_DIV - 1)) begin
                    d.div   = 8'h0;
                    d.state = nco_pkg::NCO_HS_SHIFT;
                end
            end
            nco_pkg::NCO_HS_SHIFT: begin
                d.div = q.div + 8'h1;
                if (q.div == 8'(HALF_DIV - 1)) begin
                    d.div = 8'h0;
                    d.sck = ~q.sck;
                    // msb first, next bit on rise
                    if (!q.sck) begin
                        d.shreg = {q.shreg[14:0], 1'b0};
                        if (q.bits == 5'(`NCO_WORD_BITS))
                            d.state = nco_pkg::NCO_HS_DONE;
                    end else begin
                        d.bits = q.bits + 5'h1;
                    end
                end
            end
            default: begin
                // strobe kept low through all bits
                d.fs_n  = 1'b1;
                d.done  = 1'b1;
                d.state = nco_pkg::NCO_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{nco_pkg::NCO_HS_IDLE, 8'h0, 5'h0, 16'h0, 1'b1, 1'b1,
                   1'b0};
        end else begin
            q <= d;
        end
    end

    // idles high between words; fine for the device
    assign link.serial_clock      = q.sck;
    assign link.frame_strobe_n    = q.fs_n;
    assign link.serial_input_line = q.shreg[15];
    assign cmd_ready = (q.state == nco_pkg::NCO_HS_IDLE);
    assign cmd_done  = q.done;
endmodule : nco_host

// ==== design/nco_device.sv ====
// device end: serial decode, register file, accumulator and output select
// How it works
// - top bits 11 mean phase write
// - bit 13 picks offset, low 12 data
// - reset bit clears accumulator, midscale out
// - reset bit keeps control, tuning and phase registers
// - output resumes seven clocks after release
// - host sets reset then clears it
// - power-down bits: none, dac, clock, both
// - clock halt freezes accumulator and output
// - writes still accepted during halt
// - clearing halt resumes with new values
// - bit 5 sends msb square wave
// - bit 3: msb full or halved
// - bits 1,5 zero give sine
// - bit 1 alone gives ramp
// - host keeps dac powered for waveforms
// - select bit picks tuning word
// - serial clock taken from outside
// - serial clock may idle either level
// - strobe low across whole word
// - data sampled on serial falling edge
// - words travel msb first
// - 00 control, 01 tune a, 10 tune b
`timescale 1ns/10ps
`include "nco_defs.svh"
module nco_device #(
    parameter int ACC_W = `NCO_ACC_BITS,
    parameter int DAC_W = `NCO_DAC_BITS
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // link
    nco_link_if.device            link,
    // converter and pin
    output logic [DAC_W-1:0]      dac_code,
    output logic                  converter_powerdown_bit,
    output logic                  clock_halt_bit,
    output logic                  analog_output_pin,
    output logic                  msb_output_enable
);
    typedef struct packed {
        logic [2:0]       sck_s;
        logic [1:0]       fs_s;
        logic [1:0]       sd_s;
        logic [4:0]       cnt;
        logic [15:0]      shreg;
        logic [15:0]      ctrl;
        logic [ACC_W-1:0] tuning_word_a;
        logic [ACC_W-1:0] tuning_word_b;
        logic [11:0]      phase_offset_a;
        logic [11:0]      phase_offset_b;
        logic [ACC_W-1:0] acc;
        logic [2:0]       run_cnt;
        logic [DAC_W-1:0] dac;
        logic             msb_full_rate_select;
        logic             pin;
    } nco_dev_t;
    nco_dev_t q, d;

    logic [11:0]      phase;
    logic [DAC_W-1:0] sine_code;
    logic [DAC_W-1:0] ramp_code;
    logic [15:0]      w;
    logic             fall;
    logic [13:0]      fld;
    logic [ACC_W-1:0] tw;
    nco_pkg::nco_out_t mode;

    // ==================================
    // coarse sine: folded parabola, no rom needed
    function automatic logic [DAC_W-1:0] nco_sine(input logic [11:0] p);
        logic [9:0]  x;
        logic [19:0] sq;
        logic [9:0]  mag;
        // distance from the crest, so each half starts near zero
        x   = p[10] ? p[9:0] : ~p[9:0];
        sq  = 20'(x) * 20'(x);
        mag = 10'h3FF - sq[19:10];
        // lower half stays below midscale, keeping the msb a clean square
        nco_sine = p[11] ? (10'h1FF - {1'b0, mag[9:1]})
                         : (10'h200 + {1'b0, mag[9:1]});
    endfunction : nco_sine

    always_comb begin
        d = q;
        // only edges matter, idle level free
        d.sck_s = {q.sck_s[1:0], link.serial_clock};
        d.fs_s  = {q.fs_s[0], link.frame_strobe_n};
        d.sd_s  = {q.sd_s[0], link.serial_input_line};
        fall = q.sck_s[2] & ~q.sck_s[1];
        w    = {q.shreg[14:0], q.sd_s[1]};
        fld  = w[`NCO_TW_MSB:0];
        if (q.fs_s[1]) begin
            d.cnt = 5'h0;
        end else if (fall && q.cnt < 5'(`NCO_WORD_BITS)) begin
            d.shreg = w;
            d.cnt   = q.cnt + 5'h1;
            if (q.cnt == 5'(`NCO_WORD_BITS - 1)) begin
                case (w[`NCO_CMD_HI:`NCO_CMD_LO])
                    `NCO_CMD_CTRL: d.ctrl = w;
                    `NCO_CMD_TUNE_A, `NCO_CMD_TUNE_B: begin
                        tw = (w[`NCO_CMD_HI:`NCO_CMD_LO] == `NCO_CMD_TUNE_A)
                           ? q.tuning_word_a : q.tuning_word_b;
                        // 28-bit mode follows the half-select bit too
                        if (q.ctrl[`NCO_CT_HLB])
                            tw = {fld, tw[13:0]};
                        else
                            tw = {tw[27:14], fld};
                        if (w[`NCO_CMD_HI:`NCO_CMD_LO] == `NCO_CMD_TUNE_A)
                            d.tuning_word_a = tw;
                        else
                            d.tuning_word_b = tw;
                    end
                    default: begin
                        // bit 13 selects a or b
                        if (w[`NCO_PH_SEL_BIT])
                            d.phase_offset_b = w[`NCO_PH_MSB:0];
                        else
                            d.phase_offset_a = w[`NCO_PH_MSB:0];
                    end
                endcase
            end
        end
        // ==================================
        // accumulator path
        // select bit picks tuning word
        tw = q.ctrl[`NCO_CT_FSEL] ? q.tuning_word_b : q.tuning_word_a;
        phase = q.acc[ACC_W-1 -: 12] + (q.ctrl[`NCO_CT_PSEL]
              ? q.phase_offset_b : q.phase_offset_a);
        sine_code = nco_sine(phase);
        ramp_code = phase[11] ? ~phase[10:1] : phase[10:1];
        // output select
        // bit 5 gives msb square
        // bit 3 full rate or halved
        if (q.ctrl[`NCO_CT_MSBOUT])
            mode = q.ctrl[`NCO_CT_FULLRATE] ? nco_pkg::NCO_OUT_MSB
                                            : nco_pkg::NCO_OUT_MSB_HALF;
        else if (q.ctrl[`NCO_CT_RAMP])
            mode = nco_pkg::NCO_OUT_RAMP;
        else
            mode = nco_pkg::NCO_OUT_SINE;
        if (q.ctrl[`NCO_CT_RESET]) begin
            d.acc     = '0;
            d.dac     = 10'h200;
            d.msb_full_rate_select    = 1'b0;
            d.run_cnt = 3'h0;
        end else if (!q.ctrl[`NCO_CT_HALT]) begin
            d.acc = q.acc + tw;
            // wave seen seven clocks after release
            if (q.run_cnt != `NCO_RUN_LATENCY - 3'h1)
                d.run_cnt = q.run_cnt + 3'h1;
            else
                d.dac = (mode == nco_pkg::NCO_OUT_RAMP) ? ramp_code
                                                          : sine_code;
            if (d.dac[DAC_W-1] & ~q.dac[DAC_W-1])
                d.msb_full_rate_select = ~q.msb_full_rate_select;
        end
        case (mode)
            nco_pkg::NCO_OUT_MSB:      d.pin = q.dac[DAC_W-1];
            nco_pkg::NCO_OUT_MSB_HALF: d.pin = q.msb_full_rate_select;
            default:                   d.pin = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q      <= '0;
            q.ctrl <= `NCO_CTRL_RESET;
            q.dac  <= 10'h200;
            q.fs_s <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign converter_powerdown_bit = q.ctrl[`NCO_CT_PDN];
    assign clock_halt_bit          = q.ctrl[`NCO_CT_HALT];
    assign msb_output_enable       = q.ctrl[`NCO_CT_MSBOUT];
    assign dac_code                = q.dac;
    assign analog_output_pin       = q.pin;
endmodule : nco_device

// ==== verif/nco_link_chk.sv ====
// assertions on the serial link between host and device ends
`timescale 1ns/10ps
module nco_link_chk #(
    parameter int HALF_DIV = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // link
    input wire logic serial_clock,
    input wire logic frame_strobe_n,
    input wire logic serial_input_line
);
    // ==========================================================
    // helper counters
    logic [7:0] low_cnt_q;
    logic [4:0] fall_cnt_q;
    logic       sck_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_q  <= 8'h00;
            fall_cnt_q <= 5'h00;
            sck_q      <= 1'b1;
        end else begin
            low_cnt_q  <= serial_clock ? 8'h00 : low_cnt_q + 8'h01;
            fall_cnt_q <= frame_strobe_n ? 5'h00
                          : fall_cnt_q + {4'h0, sck_q & ~serial_clock};
            sck_q      <= serial_clock;
        end
    end
    // ==========================================================
    // link assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    chk_fall_in_frame: assert property (
        $fell(serial_clock) |-> !frame_strobe_n)
        else $error("serial clock fell outside a frame");
    chk_frame_clock_high: assert property (
        $fell(frame_strobe_n) |-> serial_clock)
        else $error("frame opened with serial clock low");
    chk_data_steady: assert property (
        $fell(serial_clock) |-> $stable(serial_input_line))
        else $error("data moved at the sampling edge");
    chk_low_half: assert property (
        $rose(serial_clock) |-> low_cnt_q == 8'(HALF_DIV))
        else $error("serial clock low phase has wrong length");
    chk_sixteen_falls: assert property (
        $rose(frame_strobe_n) |-> fall_cnt_q == 5'h10)
        else $error("frame did not carry sixteen falling edges");
    chk_frame_length: assert property (
        $fell(frame_strobe_n) |-> ##[100:200] $rose(frame_strobe_n))
        else $error("frame strobe low for wrong span");
    chk_shift_high: assert property (
        (!frame_strobe_n && $changed(serial_input_line)) |-> serial_clock)
        else $error("data shifted while serial clock low");
    chk_high_half: assert property (
        $rose(serial_clock) |-> serial_clock [*4])
        else $error("serial clock high phase too short");
endmodule : nco_link_chk

// ==== verif/tb_dds_phase_sleep_output_control.sv ====
// self-checking bench: host and device joined, plus a bench-driven device
`timescale 1ns/10ps
module tb_dds_phase_sleep_output_control;
    logic        clock     = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [15:0] cmd_word  = 16'h0000;
    logic        cmd_ready;
    logic        cmd_done;
    logic [15:0] cap;
    logic [9:0]  dac;
    logic        pdn;
    logic        halt;
    logic        pin;
    logic        msb_en;
    logic        halt2;
    int          errors  = 0;
    int          checked = 0;
    nco_link_if link ();
    nco_link_if link2 ();
    always #50 clock = ~clock;
    // ==========================================================
    // ends under test
    nco_host #(.HALF_DIV(4)) u_nco_host (.clock(clock), .sys_rst(sys_rst),
        .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_word(cmd_word), .cmd_done(cmd_done));
    nco_device u_nco_device (.clock(clock), .sys_rst(sys_rst), .link(link),
        .dac_code(dac), .converter_powerdown_bit(pdn),
        .clock_halt_bit(halt), .analog_output_pin(pin),
        .msb_output_enable(msb_en));
    // second device fed by the bench to break framing on purpose
    nco_device u_nco_device_2 (.clock(clock), .sys_rst(sys_rst),
        .link(link2), .dac_code(), .converter_powerdown_bit(),
        .clock_halt_bit(halt2), .analog_output_pin(),
        .msb_output_enable());
    nco_link_chk #(.HALF_DIV(4)) u_nco_link_chk (.clock(clock),
        .sys_rst(sys_rst), .serial_clock(link.serial_clock),
        .frame_strobe_n(link.frame_strobe_n),
        .serial_input_line(link.serial_input_line));
    always @(negedge link.serial_clock) begin
        if (!link.frame_strobe_n) cap = {cap[14:0], link.serial_input_line};
    end
    // ==========================================================
    // shared tasks
    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task send(input logic [15:0] w);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        cmd_word  = w;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        check(16'(n < 400), 16'h0001);
        check(cap, w);
        repeat (8) @(negedge clock);
    endtask : send
    // dac activity over a short window; phase steps 64 counts a clock
    task moved(input logic exp);
        logic [9:0] d0;
        d0 = dac;
        repeat (20) @(negedge clock);
        check({15'h0, dac !== d0}, {15'h0, exp});
    endtask : moved
    task rises(output int r);
        logic p;
        r = 0;
        p = pin;
        repeat (512) begin
            @(negedge clock);
            if (pin === 1'b1 && p === 1'b0) r++;
            p = pin;
        end
    endtask : rises
    // bench-made frame; serial clock stands at idle outside it
    task raw(input logic [15:0] w, input int nb, input logic idle);
        // settle the idle level first, so no edge lands in the frame
        link2.serial_clock   = idle;
        repeat (4) @(negedge clock);
        link2.frame_strobe_n = 1'b0;
        repeat (4) @(negedge clock);
        for (int i = 0; i < nb; i++) begin
            link2.serial_input_line = w[15-i];
            link2.serial_clock      = 1'b1;
            repeat (4) @(negedge clock);
            link2.serial_clock = 1'b0;
            repeat (4) @(negedge clock);
        end
        link2.serial_clock      = idle;
        link2.frame_strobe_n    = 1'b1;
        link2.serial_input_line = ~link2.serial_input_line;
        repeat (8) @(negedge clock);
    endtask : raw
    // ==========================================================
    // scenarios
    task t_sleep;
        check({6'h0, dac}, 16'h0200);
        check({12'h0, halt, pdn, msb_en, pin}, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            send(16'h0100 | (16'(c) << 6));
            check({14'h0, halt, pdn}, 16'(c));
            check({6'h0, dac}, 16'h0200);
        end
        $display("test sleep done");
    endtask : t_sleep
    task t_run;
        send(16'h1100);
        send(16'h4100);
        moved(1'b0);
        send(16'h1000);
        moved(1'b1);
        check({15'h0, pin}, 16'h0000);
        send(16'h1080);
        moved(1'b0);
        send(16'hE800);
        send(16'h1480);
        check({15'h0, halt}, 16'h0001);
        moved(1'b0);
        send(16'h1400);
        moved(1'b1);
        $display("test run and halt done");
    endtask : t_run
    task t_out;
        int rf;
        int rh;
        send(16'h1028);
        check({15'h0, msb_en}, 16'h0001);
        rises(rf);
        check(16'(rf), 16'h0008);
        send(16'h1020);
        rises(rh);
        check(16'(rh), 16'h0004);
        send(16'h1002);
        check({14'h0, msb_en, pin}, 16'h0000);
        moved(1'b1);
        send(16'h0000);
        send(16'h8000);
        send(16'h1800);
        send(16'h8000);
        moved(1'b0);
        send(16'h1000);
        moved(1'b1);
        $display("test outputs done");
    endtask : t_out
    task t_frame;
        raw(16'h0080, 16, 1'b0);
        check({15'h0, halt2}, 16'h0001);
        raw(16'h0000, 15, 1'b1);
        check({15'h0, halt2}, 16'h0001);
        raw(16'h0000, 16, 1'b1);
        check({15'h0, halt2}, 16'h0000);
        $display("test framing done");
    endtask : t_frame
    task end_of_test;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        link2.serial_clock      = 1'b1;
        link2.frame_strobe_n    = 1'b1;
        link2.serial_input_line = 1'b0;
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        t_sleep();
        t_run();
        t_out();
        t_frame();
        end_of_test();
    end
    // hang guard, well beyond the roughly 4300 cycles the tests need
    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        end_of_test();
    end
endmodule : tb_dds_phase_sleep_output_control
